// >>> logic/tcc_pkg.sv
// Constants, register map and carrier types for the capture/compare timer
package tcc_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h50;
	localparam logic [7:0] OFF_IRQ_EN = 8'h54;
	localparam logic [7:0] OFF_FLAGS = 8'h58;
	localparam logic [7:0] OFF_COUNT = 8'h5c;
	localparam logic [7:0] OFF_MATCH0 = 8'h60;
	localparam logic [7:0] OFF_MATCH1 = 8'h64;
	localparam logic [7:0] OFF_CAPT0 = 8'h68;
	localparam logic [7:0] OFF_CAPT1 = 8'h6c;
	localparam int BIT_WRAP = 0;
	localparam int BIT_MATCH0 = 1;
	localparam int BIT_MATCH1 = 2;
	localparam int BIT_CAPT0 = 3;
	localparam int BIT_CAPT1 = 4;
	localparam int NUM_EVENTS = 5;
	localparam int CTRL_CLEAR = 0;
	localparam int CTRL_RUN = 1;
	localparam int CTRL_SEL_LO = 2;
	localparam int CTRL_CAPTURED_COUNT_FIRST_LO = 5;
	localparam int CTRL_CAPTURED_COUNT_SECOND_LO = 7;
	localparam int CTRL_ACT0_LO = 9;
	localparam int CTRL_ACT1_LO = 11;
	localparam int CTRL_INTERVAL = 13;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam logic [6:0] PRESCALE_RESET = 7'h00;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] ACT_KEEP = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [2:0] SEL_EXT = 3'h7;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} tcc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tcc_apb_rsp_t;
endpackage

// >>> logic/tcc_timer.sv
// Capture/compare timer channel with APB register slave
//
// Function
// - Every match, capture and wrap sets its flag regardless of interrupt enables.
// - Flags: second capture, first capture, second match, first match, wrap at 4..0.
// - Writing one to a set flag clears it and drops its request.
// - Stopped counter equal to a match value blocks clearing that match flag.
// - Writing zero to a flag bit changes nothing.
// - Writing one to a clear flag changes nothing.
// - Sixteen-bit up counter, readable anytime, writable anytime, running or stopped.
// - Both match registers compared to count each cycle, equality triggers.
// - Capture copies count into a read-only capture register.
// - First capture input feeds first capture register, second feeds second.
// - Combined interrupt is OR of the five individual requests.
// - A request counts only when enabled and its event has occurred.
// - Interrupt stays high until all pending requests cleared or disabled.
// - Edge select: 00 ignore, 01 rising, 10 falling, 11 both.
// - Match action: 00 keep, 01 low, 10 high, 11 toggle.
// - Interval mode clears counter on second match, else free running.
// - Five enable bits gate the requests at bits 4..0.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire tcc_pkg::tcc_apb_req_t apb_req,
	output tcc_pkg::tcc_apb_rsp_t apb_rsp,
	input wire logic capture_input_first,
	input wire logic capture_input_second,
	input wire logic count_clock_pin,
	output logic match_output_first,
	output logic match_output_second,
	output logic timer_irq
);
	import tcc_pkg::*;

	logic [13:0] ctrl;
	logic [4:0] irq_en;
	logic [4:0] flags;
	logic [15:0] count_value;
	logic [15:0] match_value [2];
	logic [15:0] captured_value [2];
	logic [6:0] prescale;
	logic [2:0] ext_sync;
	logic ext_state;
	logic [2:0] cap_sync [2];
	logic [1:0] cap_state;
	logic [1:0] cap_hit;
	logic [1:0] match_hit;
	logic [1:0] match_hold;
	logic tick;
	logic wrap_hit;
	logic [4:0] events;
	logic [4:0] clr_req;
	logic wr_access;
	logic rd_access;
	logic count_wr;
	logic match_wr [2];
	logic ext_rise;
	logic [31:0] next_rdata;
	logic flag_wr;
	logic en_wr;

	assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_access = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign count_wr = wr_access && apb_req.paddr == OFF_COUNT;
	assign match_wr[0] = wr_access && apb_req.paddr == OFF_MATCH0;
	assign match_wr[1] = wr_access && apb_req.paddr == OFF_MATCH1;
	assign flag_wr = wr_access && apb_req.paddr == OFF_FLAGS;
	assign en_wr = wr_access && apb_req.paddr == OFF_IRQ_EN;

	// External count clock: three-stage sync, change when stages 2 and 3 agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync <= 3'h0;
			ext_state <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[1:0], count_clock_pin};
			if (ext_sync[2] == ext_sync[1])
				ext_state <= ext_sync[2];
		end
	end
	assign ext_rise = (ext_sync[2] == ext_sync[1]) && ext_sync[2] && !ext_state;

	// Prescaler: divide by 2 to 128, or external clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prescale <= PRESCALE_RESET;
		else if (!ctrl[CTRL_RUN])
			prescale <= PRESCALE_RESET;
		else
			prescale <= prescale + 7'h01;
	end
	always_comb begin
		logic [2:0] sel;
		sel = ctrl[CTRL_SEL_LO +: 3];
		if (!ctrl[CTRL_RUN])
			tick = 1'b0;
		else if (sel == SEL_EXT)
			tick = ext_rise;
		else
			tick = &(prescale | ~((7'h02 << sel) - 7'h01));
	end

	// Match comparators, continuous
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_match
			assign match_hit[gi] = count_value == match_value[gi];
			// Event fires once per arrival at equality; no spurious match on reset values
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					match_hold[gi] <= 1'b1;
				else
					match_hold[gi] <= match_hit[gi];
			end
		end
	endgenerate

	assign wrap_hit = tick && (count_value == 16'hffff);

	// Counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_value <= COUNT_RESET;
		else if (count_wr)
			count_value <= apb_req.pwdata[15:0];
		else if (wr_access && apb_req.paddr == OFF_CTRL && apb_req.pwdata[CTRL_CLEAR])
			count_value <= COUNT_RESET;
		else if (tick) begin
			if (ctrl[CTRL_INTERVAL] && match_hit[1])
				count_value <= COUNT_RESET;
			else
				count_value <= count_value + 16'h0001;
		end
	end

	// Capture inputs: sync, edge select, copy count
	generate
		for (gi = 0; gi < 2; gi++) begin : g_capt
			logic [1:0] edge_sel;
			logic agree;
			assign edge_sel = ctrl[CTRL_CAPTURED_COUNT_FIRST_LO + 2 * gi +: 2];
			assign agree = cap_sync[gi][2] == cap_sync[gi][1];
			always_comb begin
				cap_hit[gi] = 1'b0;
				if (agree && cap_sync[gi][2] != cap_state[gi]) begin
					unique case (edge_sel)
						EDGE_NONE: cap_hit[gi] = 1'b0;
						EDGE_RISE: cap_hit[gi] = cap_sync[gi][2];
						EDGE_FALL: cap_hit[gi] = !cap_sync[gi][2];
						default: cap_hit[gi] = 1'b1;
					endcase
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_sync[gi] <= 3'h0;
					cap_state[gi] <= 1'b0;
					captured_value[gi] <= COUNT_RESET;
				end else begin
					cap_sync[gi] <= {cap_sync[gi][1:0], gi == 0 ? capture_input_first : capture_input_second};
					if (agree)
						cap_state[gi] <= cap_sync[gi][2];
					if (cap_hit[gi])
						captured_value[gi] <= count_value;
				end
			end
		end
	endgenerate

	// Match registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_value[0] <= MATCH_RESET;
			match_value[1] <= MATCH_RESET;
		end else begin
			if (match_wr[0])
				match_value[0] <= apb_req.pwdata[15:0];
			if (match_wr[1])
				match_value[1] <= apb_req.pwdata[15:0];
		end
	end

	// Match outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_output_first <= 1'b0;
			match_output_second <= 1'b0;
		end else begin
			if (events[BIT_MATCH0]) begin
				unique case (ctrl[CTRL_ACT0_LO +: 2])
					ACT_KEEP: match_output_first <= match_output_first;
					ACT_LOW: match_output_first <= 1'b0;
					ACT_HIGH: match_output_first <= 1'b1;
					default: match_output_first <= !match_output_first;
				endcase
			end
			if (events[BIT_MATCH1]) begin
				unique case (ctrl[CTRL_ACT1_LO +: 2])
					ACT_KEEP: match_output_second <= match_output_second;
					ACT_LOW: match_output_second <= 1'b0;
					ACT_HIGH: match_output_second <= 1'b1;
					default: match_output_second <= !match_output_second;
				endcase
			end
		end
	end

	// Event vector in flag layout
	always_comb begin
		events = 5'h00;
		events[BIT_WRAP] = wrap_hit;
		events[BIT_MATCH0] = match_hit[0] && !match_hold[0];
		events[BIT_MATCH1] = match_hit[1] && !match_hold[1];
		events[BIT_CAPT0] = cap_hit[0];
		events[BIT_CAPT1] = cap_hit[1];
	end

	// Clear request: ones written at flag offset, held off while stopped on a match
	always_comb begin
		clr_req = 5'h00;
		if (wr_access && apb_req.paddr == OFF_FLAGS)
			clr_req = apb_req.pwdata[4:0] & flags;
		if (!ctrl[CTRL_RUN] && match_hit[0])
			clr_req[BIT_MATCH0] = 1'b0;
		if (!ctrl[CTRL_RUN] && match_hit[1])
			clr_req[BIT_MATCH1] = 1'b0;
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags <= FLAGS_RESET;
		else
			flags <= (flags & ~clr_req) | events;
	end

	// Control and enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			irq_en <= FLAGS_RESET;
		end else if (wr_access) begin
			if (apb_req.paddr == OFF_CTRL) begin
				ctrl <= apb_req.pwdata[13:0];
				ctrl[CTRL_CLEAR] <= 1'b0;
				if (ctrl[CTRL_RUN])
					ctrl[CTRL_SEL_LO +: 3] <= ctrl[CTRL_SEL_LO +: 3];
			end
			if (apb_req.paddr == OFF_IRQ_EN)
				irq_en <= apb_req.pwdata[4:0];
		end
	end

	// Combined interrupt, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= |(((flags & ~clr_req) | events) & irq_en);
	end

	// Read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (apb_req.paddr)
			OFF_CTRL: next_rdata[13:0] = ctrl;
			OFF_IRQ_EN: next_rdata[4:0] = irq_en;
			OFF_FLAGS: next_rdata[4:0] = flags;
			OFF_COUNT: next_rdata[15:0] = count_value;
			OFF_MATCH0: next_rdata[15:0] = match_value[0];
			OFF_MATCH1: next_rdata[15:0] = match_value[1];
			OFF_CAPT0: next_rdata[15:0] = captured_value[0];
			OFF_CAPT1: next_rdata[15:0] = captured_value[1];
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// APB answer: data latched in setup, ready in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			apb_rsp <= '0;
		else begin
			if (rd_access)
				apb_rsp.prdata <= next_rdata;
			apb_rsp.pready <= apb_req.psel && !apb_req.penable;
			apb_rsp.pslverr <= 1'b0;
		end
	end

	AST_WRAP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		wrap_hit && !wr_access |=> flags[BIT_WRAP] && count_value == 16'h0000)
		else $error("wrap flag not set");

	AST_EVENT_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		events[BIT_CAPT0] |=> flags[BIT_CAPT0])
		else $error("capture flag missing");

	AST_EVENT_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		events[BIT_WRAP] |=> flags[BIT_WRAP])
		else $error("wrap flag missing");

	AST_CLEAR_WORKS: assert property (@(posedge pclk) disable iff (!presetn)
		flag_wr && apb_req.pwdata[BIT_CAPT1] && !events[BIT_CAPT1] |=> !flags[BIT_CAPT1])
		else $error("flag not cleared");

	AST_CLEAR_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		flag_wr && apb_req.pwdata[4:0] == flags && ctrl[CTRL_RUN] && events == 5'h00 |=> !timer_irq)
		else $error("irq kept after clear");

	AST_ZERO_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
		flag_wr && !apb_req.pwdata[BIT_CAPT0] && flags[BIT_CAPT0] |=> flags[BIT_CAPT0])
		else $error("zero write changed flag");

	AST_ONE_UNSET: assert property (@(posedge pclk) disable iff (!presetn)
		flag_wr && !flags[BIT_CAPT0] && !events[BIT_CAPT0] |=> !flags[BIT_CAPT0])
		else $error("clear of unset flag set it");

	AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[CTRL_RUN] && match_hit[0] && flags[BIT_MATCH0] |=> flags[BIT_MATCH0])
		else $error("held match flag cleared");

	AST_STOP_HOLD_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[CTRL_RUN] && match_hit[1] && flags[BIT_MATCH1] |=> flags[BIT_MATCH1])
		else $error("held second match flag cleared");

	AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !wr_access && !(ctrl[CTRL_INTERVAL] && match_hit[1])
		|=> count_value == 16'($past(count_value) + 16'h0001)) else $error("count did not step");

	AST_COUNT_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		count_wr |=> count_value == $past(apb_req.pwdata[15:0]))
		else $error("count not loaded");

	AST_MATCH_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
		match_hit[0] && !match_hold[0] |=> flags[BIT_MATCH0])
		else $error("match not flagged");

	AST_CAPTURE_COPY: assert property (@(posedge pclk) disable iff (!presetn)
		cap_hit[1] |=> captured_value[1] == $past(count_value))
		else $error("capture value wrong");

	AST_CAPTURE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!cap_hit[0] |=> $stable(captured_value[0]))
		else $error("capture register changed");

	AST_CAPTURE_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		cap_hit[0] |=> captured_value[0] == $past(count_value))
		else $error("first capture value wrong");

	AST_IRQ_OR: assert property (@(posedge pclk) disable iff (!presetn)
		|(flags & irq_en) && !flag_wr && !en_wr |=> timer_irq)
		else $error("irq missing");

	AST_IRQ_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(flags & irq_en)) && events == 5'h00 |=> !timer_irq)
		else $error("irq without request");

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		##1 timer_irq == |($past(flags & ~clr_req | events) & $past(irq_en)))
		else $error("irq level wrong");

	AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		timer_irq && |(flags & irq_en & ~clr_req) && !en_wr |=> timer_irq)
		else $error("irq dropped early");

	AST_EDGE_NONE: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[CTRL_CAPTURED_COUNT_FIRST_LO +: 2] == EDGE_NONE |-> !cap_hit[0])
		else $error("ignored input captured");

	AST_HIGH_ACT: assert property (@(posedge pclk) disable iff (!presetn)
		events[BIT_MATCH0] && ctrl[CTRL_ACT0_LO +: 2] == ACT_HIGH |=> match_output_first)
		else $error("output not high");

	AST_LOW_ACT: assert property (@(posedge pclk) disable iff (!presetn)
		events[BIT_MATCH1] && ctrl[CTRL_ACT1_LO +: 2] == ACT_LOW |=> !match_output_second)
		else $error("output not low");

	AST_KEEP_ACT: assert property (@(posedge pclk) disable iff (!presetn)
		events[BIT_MATCH0] && ctrl[CTRL_ACT0_LO +: 2] == ACT_KEEP |=> $stable(match_output_first))
		else $error("output changed on keep");

	AST_INTERVAL: assert property (@(posedge pclk) disable iff (!presetn)
		tick && ctrl[CTRL_INTERVAL] && match_hit[1] && !count_wr |=> count_value == 16'h0000)
		else $error("no interval clear");

	AST_ENABLE_BITS: assert property (@(posedge pclk) disable iff (!presetn)
		en_wr |=> irq_en == $past(apb_req.pwdata[4:0]))
		else $error("enable bits not written");

	AST_FLAG_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn)
		rd_access && apb_req.paddr == OFF_FLAGS |=> apb_rsp.prdata == {27'h0, $past(flags)})
		else $error("flag read layout wrong");
endmodule
`default_nettype wire

// >>> verif/tcc_pin_model.sv
// Pin-side model driving the capture inputs and the count clock pin
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model (
	input wire logic pclk,
	output logic capture_input_first,
	output logic capture_input_second,
	output logic count_clock_pin
);
	initial begin
		capture_input_first = 1'b0;
		capture_input_second = 1'b0;
		count_clock_pin = 1'b0;
	end
	// Flips one capture pin just after a clock edge
	task automatic flip(input bit second);
		@(posedge pclk);
		if (second) begin
			capture_input_second <= !capture_input_second;
		end else begin
			capture_input_first <= !capture_input_first;
		end
	endtask
	// Pulses the count clock pin, eight cycles per period
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge pclk);
			count_clock_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			count_clock_pin <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/tcc_timer_tb.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_tb;
	import tcc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	tcc_apb_req_t req = '0;
	tcc_apb_rsp_t rsp;
	logic cap_a, cap_b, ext_clk, out_a, out_b, irq, o, x;
	logic [31:0] q, d;
	logic [31:0] run = 32'h1 << CTRL_RUN;
	logic [15:0] c0;
	logic [1:0] acts [5] = '{ACT_HIGH, ACT_KEEP, 2'h3, ACT_LOW, 2'h3};
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	tcc_pin_model i_tcc_pin_model (.pclk(pclk), .capture_input_first(cap_a), .capture_input_second(cap_b),
		.count_clock_pin(ext_clk));
	tcc_timer i_tcc_timer (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.capture_input_first(cap_a), .capture_input_second(cap_b), .count_clock_pin(ext_clk),
		.match_output_first(out_a), .match_output_second(out_b), .timer_irq(irq));
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 40);
		if (n >= 40) err_total++;
		q = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(a, 1'b0, 32'h0);
		chk(q, exp, m);
	endtask
	function automatic logic exp_irq(input logic [4:0] f, input logic [4:0] e);
		return |(f & e);
	endfunction
	function automatic logic next_out(input logic [1:0] a, input logic cur);
		case (a)
			ACT_KEEP: return cur;
			ACT_LOW: return 1'b0;
			ACT_HIGH: return 1'b1;
			default: return !cur;
		endcase
	endfunction
	initial begin
		void'($urandom(42915));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(OFF_FLAGS + 8'(4 * i), 32'h0, "reset value");
		rd(8'h70, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++) begin
			d = $urandom();
			apb(OFF_COUNT, 1'b1, d);
			rd(OFF_COUNT, {16'h0, d[15:0]}, "count");
			apb(OFF_MATCH0 + 8'(4 * i[0]), 1'b1, ~d);
			rd(OFF_MATCH0 + 8'(4 * i[0]), {16'h0, ~d[15:0]}, "match reg");
		end
		apb(OFF_MATCH0, 1'b1, 32'h40);
		apb(OFF_MATCH1, 1'b1, 32'h0);
		apb(OFF_COUNT, 1'b1, 32'h30);
		apb(OFF_FLAGS, 1'b1, 32'h1f);
		apb(OFF_CTRL, 1'b1, run);
		repeat (40) @(posedge pclk);
		rd(OFF_FLAGS, 32'h2, "match flag");
		chk({31'h0, irq}, {31'h0, exp_irq(5'h2, 5'h0)}, "masked");
		apb(OFF_IRQ_EN, 1'b1, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, exp_irq(5'h2, 5'h2)}, "irq on");
		apb(OFF_FLAGS, 1'b1, 32'h0);
		rd(OFF_FLAGS, 32'h2, "zero write");
		chk({31'h0, irq}, 32'h1, "zero write irq");
		apb(OFF_FLAGS, 1'b1, 32'h8);
		rd(OFF_FLAGS, 32'h2, "clear unset");
		apb(OFF_FLAGS, 1'b1, 32'h2);
		repeat (2) @(posedge pclk);
		rd(OFF_FLAGS, 32'h0, "cleared");
		chk({31'h0, irq}, 32'h0, "irq dropped");
		apb(OFF_IRQ_EN, 1'b1, 32'h5);
		apb(OFF_COUNT, 1'b1, 32'hfff8);
		repeat (30) @(posedge pclk);
		rd(OFF_FLAGS, 32'h5, "wrap");
		apb(OFF_FLAGS, 1'b1, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, exp_irq(5'h4, 5'h5)}, "irq held");
		apb(OFF_IRQ_EN, 1'b1, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq disabled");
		for (int e = 0; e < 4; e++) begin
			apb(OFF_CTRL, 1'b1, run | (e << CTRL_CAPTURED_COUNT_FIRST_LO) | (e << CTRL_CAPTURED_COUNT_SECOND_LO));
			for (int k = 0; k < 4; k++) begin
				apb(OFF_FLAGS, 1'b1, 32'h18);
				apb(OFF_COUNT, 1'b0, 32'h0);
				c0 = q[15:0];
				i_tcc_pin_model.flip(k[0]);
				repeat (10) @(posedge pclk);
				x = (k[0] ? cap_b : cap_a) ? e[0] : e[1];
				apb(OFF_FLAGS, 1'b0, 32'h0);
				chk(q & 32'h18, x ? (k[0] ? 32'h10 : 32'h8) : 32'h0, "capture flag");
				apb(k[0] ? OFF_CAPT1 : OFF_CAPT0, 1'b0, 32'h0);
				if (x) chk({31'h0, (q[15:0] - c0) < 16'd16}, 32'h1, "captured");
			end
		end
		d = q;
		apb(OFF_CAPT1, 1'b1, 32'hffff);
		rd(OFF_CAPT1, d, "capture read only");
		apb(OFF_MATCH1, 1'b1, 32'h40);
		o = 1'b0;
		foreach (acts[i]) begin
			apb(OFF_CTRL, 1'b1, run | (acts[i] << CTRL_ACT0_LO) | (acts[i] << CTRL_ACT1_LO));
			apb(OFF_COUNT, 1'b1, 32'h3c);
			repeat (24) @(posedge pclk);
			o = next_out(acts[i], o);
			chk({30'h0, out_b, out_a}, {30'h0, o, o}, "match pins");
		end
		apb(OFF_CTRL, 1'b1, 32'h0);
		apb(OFF_COUNT, 1'b1, 32'h40);
		apb(OFF_FLAGS, 1'b1, 32'h2);
		apb(OFF_FLAGS, 1'b0, 32'h0);
		chk(q & 32'h2, 32'h2, "stopped equal");
		apb(OFF_COUNT, 1'b1, 32'h41);
		apb(OFF_FLAGS, 1'b1, 32'h2);
		apb(OFF_FLAGS, 1'b0, 32'h0);
		chk(q & 32'h2, 32'h0, "count moved");
		apb(OFF_MATCH1, 1'b1, 32'h10);
		apb(OFF_COUNT, 1'b1, 32'h0);
		apb(OFF_CTRL, 1'b1, run | (32'h1 << CTRL_INTERVAL));
		repeat (200) @(posedge pclk);
		apb(OFF_COUNT, 1'b0, 32'h0);
		chk({31'h0, q[15:0] <= 16'h10}, 32'h1, "interval");
		apb(OFF_CTRL, 1'b1, 32'h0);
		apb(OFF_COUNT, 1'b1, 32'h0);
		apb(OFF_CTRL, 1'b1, run | (32'h7 << CTRL_SEL_LO));
		i_tcc_pin_model.pulse(5);
		rd(OFF_COUNT, 32'h5, "external count");
		complete_run();
	end
endmodule
`default_nettype wire
